/* File: smbsp_pkg.sv */
// shared constants, types and sequencing table for the smbus register port
package smbsp_pkg;
  localparam logic [6:0] ADDR_DEFAULT = 7'h2e;
  localparam logic [6:0] ADDR_SEL_LOW = 7'h2c;
  localparam logic [6:0] ADDR_SEL_HIGH = 7'h2d;
  localparam logic [7:0] CFG1_PTR = 8'h40;
  localparam int BUS_TIMEOUT_DISABLE_BIT = 6;
  localparam int REF_CLK_NS = 20;
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / REF_CLK_NS;
  localparam int SCL_QUARTER_NS = 2500;
  localparam int SCL_QCYC = SCL_QUARTER_NS / REF_CLK_NS;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [1:0] MAX_WR_BYTES = 2'h2;
  localparam logic [2:0] PU_SETTLE = 3'h4;
  localparam logic [1:0] PEND_INIT = 2'h1;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_RX = 3'b001, D_ACK = 3'b010, D_TX = 3'b011, D_MACK = 3'b100
  } smbsp_dstate_t;
  typedef enum logic [1:0] {
    K_SEND = 2'b00, K_WRITE = 2'b01, K_RECV = 2'b10, K_READ = 2'b11
  } smbsp_kind_t;
  typedef enum logic [2:0] {
    OP_START = 3'b000, OP_WADDR = 3'b001, OP_RADDR = 3'b010, OP_PTR = 3'b011,
    OP_DATA = 3'b100, OP_RD = 3'b101, OP_STOP = 3'b110
  } smbsp_op_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00, H_START = 2'b01, H_BIT = 2'b10, H_STOP = 2'b11
  } smbsp_hstate_t;

  // bus step list of each protocol
  function automatic smbsp_op_t smbsp_op_of(input smbsp_kind_t k, input logic [2:0] s);
    smbsp_op_t o;
    o = OP_STOP;
    if (s == 3'h0) begin
      o = OP_START;
    end else if (s == 3'h1) begin
      o = (k == K_RECV) ? OP_RADDR : OP_WADDR;
    end else if (s == 3'h2) begin
      o = (k == K_RECV) ? OP_RD : OP_PTR;
    end else if (s == 3'h3 && k == K_WRITE) begin
      o = OP_DATA;
    end else if (s == 3'h3 && k == K_READ) begin
      o = OP_START;
    end else if (s == 3'h4 && k == K_READ) begin
      o = OP_RADDR;
    end else if (s == 3'h5 && k == K_READ) begin
      o = OP_RD;
    end
    return o;
  endfunction
endpackage

/* File: smbsp_if.sv */
// two-wire bus between master and slave, wired-and with pull-ups
`timescale 1ns/10ps
interface smbsp_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host (output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe,
                input scl, input sda);
  modport device (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface // smbsp_if

/* File: smbsp_device.sv */
// slave end: address match, pointer and register access over the two-wire bus
`timescale 1ns/10ps
module smbsp_device import smbsp_pkg::*; #(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  // clocks and reset
  input wire logic ref_clk,
  input wire logic link_clk,
  input wire logic rst,
  // bus
  smbsp_if.device bus,
  // straps
  input wire logic address_mode_strap,
  input wire logic address_select_strap,
  // register port, ref_clk
  output logic [7:0] reg_ptr,
  output logic reg_wr,
  output logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data,
  output logic bus_timeout_disable,
  // status, link_clk
  output logic [6:0] slave_addr,
  output logic addr_locked
);
  localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);

  // ---------------- link domain ----------------
  logic rst_m, link_rst;
  logic [3:0] sy1, sy2, sy3, filt, filt_p;
  logic [2:0] pu_cnt;
  logic mode_q;
  smbsp_dstate_t state;
  logic [3:0] bitcnt;
  logic [7:0] shift, txsh, read_word, lk_ptr, lk_wdata;
  logic [1:0] byte_idx;
  logic is_addr, rd_dir, ack_pend, oe, lk_wr, lk_req, link_wait;
  logic ack_m, ack_s, ack_seen, tmo_m, tmo_s;
  logic req_m, req_s, req_seen, ack_tgl, wait_m, wait_s, tmo_lvl;
  logic [1:0] pend;
  logic [7:0] rd_hold;
  logic [TO_W-1:0] to_cnt;

  wire scl_f = filt[1];
  wire sda_f = filt[0];
  wire scl_rise = scl_f && !filt_p[1];
  wire scl_fall = !scl_f && filt_p[1];
  wire start_c = scl_f && filt_p[1] && !sda_f && filt_p[0];
  wire stop_c = scl_f && filt_p[1] && sda_f && !filt_p[0];
  wire pu_done = (pu_cnt == PU_SETTLE);
  wire [7:0] full = {shift[6:0], sda_f};
  wire byte_done = (state == D_RX) && scl_rise && (bitcnt == LAST_BIT);
  wire addr_hit = (full[7:1] == slave_addr);
  wire data_ok = (byte_idx < MAX_WR_BYTES);
  wire [6:0] addr_now = mode_q ? ADDR_DEFAULT : (filt[2] ? ADDR_SEL_HIGH : ADDR_SEL_LOW);
  // change only counts once second and third stages agree
  wire [3:0] next_filt = (sy2 & sy3) | (filt & (sy2 | sy3));

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = oe;

  always_ff @(posedge link_clk) begin
    rst_m <= rst;
    link_rst <= rst_m;
    sy1 <= {address_mode_strap, address_select_strap, bus.scl, bus.sda};
    sy2 <= sy1;
    sy3 <= sy2;
    tmo_m <= tmo_lvl;
    tmo_s <= tmo_m;
    ack_m <= ack_tgl;
    ack_s <= ack_m;
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      filt <= 4'hf;
      filt_p <= 4'hf;
      pu_cnt <= 3'h0;
      mode_q <= 1'b1;
      slave_addr <= ADDR_DEFAULT;
      addr_locked <= 1'b0;
    end else begin
      filt <= next_filt;
      filt_p <= filt;
      if (!pu_done) begin
        pu_cnt <= pu_cnt + 3'h1;
      end
      if (pu_cnt == PU_SETTLE - 3'h1) begin
        mode_q <= filt[3];
      end
      if (!addr_locked) begin
        slave_addr <= addr_now;
      end
      if (byte_done && is_addr && addr_hit) begin
        addr_locked <= 1'b1;
      end
    end
  end

  // bit and byte sequencing
  always_ff @(posedge link_clk) begin
    if (link_rst || tmo_s) begin
      state <= D_IDLE;
      oe <= 1'b0;
      bitcnt <= 4'h0;
      byte_idx <= 2'h0;
      is_addr <= 1'b0;
      shift <= 8'h00;
      txsh <= 8'h00;
      rd_dir <= 1'b0;
      ack_pend <= 1'b0;
    end else if (start_c && pu_done) begin
      state <= D_RX;
      oe <= 1'b0;
      bitcnt <= 4'h0;
      byte_idx <= 2'h0;
      is_addr <= 1'b1;
    end else if (stop_c) begin
      state <= D_IDLE;
      oe <= 1'b0;
    end else begin
      case (state)
        D_RX: begin
          if (scl_rise) begin
            shift <= full;
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == ACK_BIT) begin
            oe <= ack_pend;
            state <= ack_pend ? D_ACK : D_IDLE;
          end
          if (byte_done) begin
            ack_pend <= is_addr ? addr_hit : data_ok;
            if (is_addr) begin
              rd_dir <= full[0];
            end else begin
              byte_idx <= byte_idx + 2'h1;
            end
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            bitcnt <= 4'h0;
            is_addr <= 1'b0;
            if (is_addr && rd_dir) begin
              state <= D_TX;
              txsh <= read_word;
              oe <= !read_word[7];
            end else begin
              state <= D_RX;
              oe <= 1'b0;
            end
          end
        end
        D_TX: begin
          if (scl_rise) begin
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == ACK_BIT) begin
            oe <= 1'b0;
            state <= D_MACK;
          end else if (scl_fall) begin
            txsh <= {txsh[6:0], 1'b0};
            oe <= !txsh[6];
          end
        end
        D_MACK: begin
          // exactly one byte per read, whatever the master answers
          if (scl_rise) begin
            state <= D_IDLE;
          end
        end
        default: state <= D_IDLE;
      endcase
    end
  end

  // pointer and data toward the register side; held stable until next toggle
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lk_ptr <= 8'h00;
      lk_wdata <= 8'h00;
      lk_wr <= 1'b0;
      lk_req <= 1'b0;
      read_word <= 8'h00;
      ack_seen <= 1'b0;
      link_wait <= 1'b0;
    end else begin
      link_wait <= (state != D_IDLE) && !scl_f;
      if (byte_done && !is_addr && byte_idx == 2'h0) begin
        lk_ptr <= full;
        lk_wr <= 1'b0;
        lk_req <= !lk_req;
      end else if (byte_done && !is_addr && byte_idx == 2'h1) begin
        lk_wdata <= full;
        lk_wr <= 1'b1;
        lk_req <= !lk_req;
      end
      if (ack_s != ack_seen) begin
        ack_seen <= ack_s;
        read_word <= rd_hold;
      end
    end
  end

  // ---------------- ref domain ----------------
  wire req_new = (req_s != req_seen);

  always_ff @(posedge ref_clk) begin
    req_m <= lk_req;
    req_s <= req_m;
    wait_m <= link_wait;
    wait_s <= wait_m;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_seen <= 1'b0;
      reg_ptr <= 8'h00;
      reg_wr <= 1'b0;
      reg_wr_data <= 8'h00;
      pend <= PEND_INIT;
      rd_hold <= 8'h00;
      ack_tgl <= 1'b0;
      bus_timeout_disable <= 1'b0;
    end else begin
      req_seen <= req_s;
      reg_wr <= req_new && lk_wr;
      // one spare cycle so a read after a write sees the new value
      pend <= {pend[0], req_new};
      if (req_new) begin
        reg_ptr <= lk_ptr;
        reg_wr_data <= lk_wdata;
        if (lk_wr && lk_ptr == CFG1_PTR) begin
          bus_timeout_disable <= lk_wdata[BUS_TIMEOUT_DISABLE_BIT];
        end
      end
      if (pend[1]) begin
        rd_hold <= reg_rd_data;
        ack_tgl <= !ack_tgl;
      end
    end
  end

  // clock held low mid-transfer too long frees the bus
  always_ff @(posedge ref_clk) begin
    if (rst || !wait_s || bus_timeout_disable) begin
      to_cnt <= '0;
      tmo_lvl <= 1'b0;
    end else if (to_cnt == TO_W'(TIMEOUT_CYCLES - 1)) begin
      tmo_lvl <= 1'b1;
    end else begin
      to_cnt <= to_cnt + 1'b1;
    end
  end
endmodule // smbsp_device

/* File: smbsp_host.sv */
// master end: runs send, write, receive and read byte protocols on the bus
`timescale 1ns/10ps
module smbsp_host import smbsp_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus
  smbsp_if.host bus,
  // command
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_ptr,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  // response
  output logic done,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  smbsp_hstate_t hstate;
  smbsp_kind_t kind_q;
  logic [6:0] addr_q;
  logic [7:0] ptr_q, data_q, txb, rxb;
  logic [7:0] qcnt;
  logic [1:0] phase;
  logic [2:0] step;
  logic [3:0] bitn;
  logic tx_mode, nack, scl_oe, sda_oe;
  logic sy1, sy2, sy3, sda_f;

  wire tick = (qcnt == 8'(SCL_QCYC - 1));
  wire last_q = tick && (phase == 2'h3);
  wire ack_slot = (bitn == ACK_BIT);
  wire [2:0] next_step = step + 3'h1;
  wire smbsp_op_t nx_op = nack ? OP_STOP : smbsp_op_of(kind_q, next_step);

  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe = scl_oe;
  assign bus.host_sda_oe = sda_oe;

  always_ff @(posedge ref_clk) begin
    sy1 <= bus.sda;
    sy2 <= sy1;
    sy3 <= sy2;
    if (sy2 == sy3) begin
      sda_f <= sy3;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || hstate == H_IDLE || tick) begin
      qcnt <= 8'h00;
    end else begin
      qcnt <= qcnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hstate <= H_IDLE;
      cmd_ready <= 1'b1;
      done <= 1'b0;
      rsp_data <= 8'h00;
      rsp_nack <= 1'b0;
      kind_q <= K_SEND;
      addr_q <= 7'h00;
      ptr_q <= 8'h00;
      data_q <= 8'h00;
      txb <= 8'h00;
      rxb <= 8'h00;
      phase <= 2'h0;
      step <= 3'h0;
      bitn <= 4'h0;
      tx_mode <= 1'b0;
      nack <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      // free data one cycle after the clock falls into the acknowledge slot, before the slave pulls it
      if (hstate == H_BIT && ack_slot && phase == 2'h0 && !tick) begin
        sda_oe <= 1'b0;
      end
      if (hstate == H_IDLE && cmd_valid) begin
        kind_q <= smbsp_kind_t'(cmd_kind);
        addr_q <= cmd_addr;
        ptr_q <= cmd_ptr;
        data_q <= cmd_data;
        cmd_ready <= 1'b0;
        nack <= 1'b0;
        step <= 3'h0;
        phase <= 2'h0;
        hstate <= H_START;
      end else if (tick) begin
        phase <= phase + 2'h1;
        case (hstate)
          H_START: begin
            // data high before clock high, so it also serves as repeated start
            if (phase == 2'h0) sda_oe <= 1'b0;
            if (phase == 2'h1) scl_oe <= 1'b0;
            if (phase == 2'h2) sda_oe <= 1'b1;
            if (phase == 2'h3) scl_oe <= 1'b1;
          end
          H_BIT: begin
            // data moves only with clock low
            if (phase == 2'h0) sda_oe <= tx_mode && !ack_slot && !txb[7];
            if (phase == 2'h1) scl_oe <= 1'b0;
            if (phase == 2'h2 && !ack_slot) rxb <= {rxb[6:0], sda_f};
            if (phase == 2'h2 && ack_slot && tx_mode && sda_f) nack <= 1'b1;
            if (phase == 2'h3) begin
              scl_oe <= 1'b1;
              txb <= {txb[6:0], 1'b0};
              bitn <= bitn + 4'h1;
            end
          end
          H_STOP: begin
            if (phase == 2'h0) sda_oe <= 1'b1;
            if (phase == 2'h1) scl_oe <= 1'b0;
            if (phase == 2'h2) sda_oe <= 1'b0;
            if (phase == 2'h3) begin
              hstate <= H_IDLE;
              done <= 1'b1;
              cmd_ready <= 1'b1;
              rsp_data <= rxb;
              rsp_nack <= nack;
            end
          end
          default: hstate <= H_IDLE;
        endcase
        if (last_q && hstate != H_STOP && (hstate != H_BIT || ack_slot)) begin
          step <= next_step;
          bitn <= 4'h0;
          tx_mode <= 1'b1;
          hstate <= H_BIT;
          case (nx_op)
            OP_START: hstate <= H_START;
            OP_STOP: hstate <= H_STOP;
            OP_WADDR: txb <= {addr_q, 1'b0};
            OP_RADDR: txb <= {addr_q, 1'b1};
            OP_PTR: txb <= ptr_q;
            OP_DATA: txb <= data_q;
            default: tx_mode <= 1'b0;
          endcase
        end
      end
    end
  end
endmodule // smbsp_host

/* File: smbsp_assertions.sv */
// bus-level assertions for the two-wire link between master and slave ends
`timescale 1ns/10ps
module smbsp_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus drivers
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  // resolved lines
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic [4:0] rc;
  // longest legal low drive: address acknowledge followed by eight zero read bits
  localparam logic [12:0] HOLD_MAX = 13'h1388;
  logic [12:0] hold_cnt;
  wire [12:0] next_hold = !dev_sda_oe ? 13'h0000 : (hold_cnt == 13'h1fff) ? hold_cnt : hold_cnt + 13'h0001;
  wire start_seen = scl && scl_q && sda_q && !sda;
  wire stop_seen = scl && scl_q && !sda_q && sda;
  wire scl_rise = scl && !scl_q;
  // clock rises since the last start; parked at 31 while idle so idle never looks like a first byte
  wire [4:0] next_rc = start_seen ? 5'h00 : stop_seen ? 5'h1f : (scl_rise && rc != 5'h1f) ? rc + 5'h01 : rc;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rc <= 5'h1f;
      hold_cnt <= 13'h0000;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      rc <= next_rc;
      hold_cnt <= next_hold;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  open_drain_a: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
    else $error("open-drain output value not low");
  dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("slave changed data while clock high");
  no_fight_a: assert property (dev_sda_oe |-> !host_sda_oe)
    else $error("both ends drive data at once");
  ack_slot_a: assert property ($rose(dev_sda_oe) && rc < 5'h09 |-> rc == 5'h08)
    else $error("address acknowledge outside ninth bit");
  addr_quiet_a: assert property (rc < 5'h08 |-> !dev_sda_oe)
    else $error("slave drove data during address bits");
  dev_release_a: assert property (hold_cnt < HOLD_MAX)
    else $error("slave held data line too long");
  start_gap_a: assert property (start_seen |-> ##[100:150] !scl)
    else $error("clock not lowered after start");
  stop_idle_a: assert property (stop_seen |-> scl [*8])
    else $error("clock not left high after stop");

  cover property (start_seen);
  cover property ($rose(dev_sda_oe) && rc == 5'h08);
  cover property (stop_seen);
endmodule // smbsp_assertions

/* File: smbus_slave_register_port_bench.sv */
// self-checking bench joining master and slave ends of the smbus register port
`timescale 1ns/10ps
module smbus_slave_register_port_bench import smbsp_pkg::*;;
  logic ref_clk, link_clk, rst;
  logic address_mode_strap, address_select_strap;
  logic cmd_valid, cmd_ready, done, rsp_nack;
  logic [1:0] cmd_kind;
  logic [6:0] cmd_addr, slave_addr;
  logic [7:0] cmd_ptr, cmd_data, rsp_data, reg_ptr, reg_wr_data, reg_rd_data;
  logic reg_wr, bus_timeout_disable, addr_locked;
  logic [7:0] user_mem [256];
  logic [7:0] exp_mem [256];
  logic [7:0] last_ptr, last_data, p1, d1, p2, d2;
  int fails, n_tests, wr_cnt, seed;

  smbsp_if bus_if();
  smbsp_host smbsp_host_i (.ref_clk(ref_clk), .rst(rst), .bus(bus_if), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_ptr(cmd_ptr), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .done(done), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  // short bus timeout, still above the 250-cycle clock-low phase of normal traffic
  smbsp_device #(.TIMEOUT_CYCLES(600)) smbsp_device_i (.ref_clk(ref_clk), .link_clk(link_clk), .rst(rst),
    .bus(bus_if), .address_mode_strap(address_mode_strap), .address_select_strap(address_select_strap),
    .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .bus_timeout_disable(bus_timeout_disable), .slave_addr(slave_addr), .addr_locked(addr_locked));
  smbsp_assertions smbsp_assertions_i (.ref_clk(ref_clk), .rst(rst),
    .host_scl_o(bus_if.host_scl_o), .host_scl_oe(bus_if.host_scl_oe), .host_sda_o(bus_if.host_sda_o),
    .host_sda_oe(bus_if.host_sda_oe), .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe),
    .scl(bus_if.scl), .sda(bus_if.sda));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #7.5 link_clk = ~link_clk;
  end

  // user register file behind the slave's register port
  assign reg_rd_data = user_mem[reg_ptr];
  always @(posedge ref_clk) begin
    if (reg_wr === 1'b1) begin
      user_mem[reg_ptr] <= reg_wr_data;
      last_ptr <= reg_ptr;
      last_data <= reg_wr_data;
      wr_cnt <= wr_cnt + 1;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic run_cmd(input logic [1:0] k, input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_ptr <= p;
    cmd_data <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 30000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 30000) fails++;
    check({7'h00, cmd_ready}, 8'h01);
  endtask

  task automatic do_reset(input logic mode, input logic sel);
    address_mode_strap <= mode;
    address_select_strap <= sel;
    rst <= 1'b1;
    // three edges span four link edges, enough for the link-side synchroniser
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (100) @(posedge ref_clk);
  endtask

  initial begin
    repeat (98000) @(posedge ref_clk);
    fails++;
    end_sim();
  end

  initial begin
    cmd_valid = 1'b0;
    cmd_kind = 2'h0;
    cmd_addr = 7'h00;
    cmd_ptr = 8'h00;
    cmd_data = 8'h00;
    address_mode_strap = 1'b1;
    address_select_strap = 1'b0;
    rst = 1'b1;
    fails = 0;
    n_tests = 0;
    wr_cnt = 0;
    seed = $urandom(15178);
    for (int i = 0; i < 256; i++) begin
      user_mem[i] = 8'($urandom);
      exp_mem[i] = user_mem[i];
    end
    p1 = 8'($urandom) & 8'h3f;
    d1 = 8'($urandom);
    p2 = (8'($urandom) & 8'h3f) | 8'h80;
    d2 = 8'($urandom) | 8'h40;
    do_reset(1'b1, 1'b0);
    check({1'b0, slave_addr}, {1'b0, ADDR_DEFAULT});
    do_reset(1'b0, 1'b0);
    check({1'b0, slave_addr}, 8'h2c);
    address_select_strap <= 1'b1;
    repeat (20) @(posedge ref_clk);
    check({1'b0, slave_addr}, 8'h2d);
    // another slave's address: no acknowledge, nothing stored
    run_cmd(K_WRITE, ADDR_SEL_LOW, p1, d1);
    check({7'h00, rsp_nack}, 8'h01);
    check(8'(wr_cnt), 8'h00);
    check({7'h00, addr_locked}, 8'h00);
    run_cmd(K_WRITE, ADDR_SEL_HIGH, p1, d1);
    exp_mem[p1] = d1;
    check({7'h00, rsp_nack}, 8'h00);
    check(last_ptr, p1);
    check(last_data, d1);
    check(8'(wr_cnt), 8'h01);
    check({7'h00, addr_locked}, 8'h01);
    address_select_strap <= 1'b0;
    repeat (20) @(posedge ref_clk);
    check({1'b0, slave_addr}, 8'h2d);
    run_cmd(K_WRITE, ADDR_SEL_HIGH, CFG1_PTR, d2);
    exp_mem[CFG1_PTR] = d2;
    check({7'h00, bus_timeout_disable}, 8'h01);
    run_cmd(K_SEND, ADDR_SEL_HIGH, p2, 8'h00);
    check(reg_ptr, p2);
    check(8'(wr_cnt), 8'h02);
    run_cmd(K_RECV, ADDR_SEL_HIGH, 8'h00, 8'h00);
    check(rsp_data, exp_mem[p2]);
    check(reg_ptr, p2);
    run_cmd(K_READ, ADDR_SEL_HIGH, p1, 8'h00);
    check(rsp_data, exp_mem[p1]);
    check({7'h00, rsp_nack}, 8'h00);
    run_cmd(K_READ, ADDR_SEL_HIGH, CFG1_PTR, 8'h00);
    check(rsp_data, exp_mem[CFG1_PTR]);
    check(8'(wr_cnt), 8'h02);
    end_sim();
  end
endmodule // smbus_slave_register_port_bench
